/* include/adc_timing_pkg.sv */
// Constants shared by the converter timing control block.
package adc_timing_pkg;

    // ----------------------------------------------------------------
    // Register map.
    // ----------------------------------------------------------------
    localparam logic [3:0]  ADDR_CONTROL_TWO = 4'h0; // Control register.
    localparam logic [3:0]  ADDR_STATUS      = 4'h4; // Sequencer status.
    localparam logic [7:0]  CONTROL_RESET    = 8'h00; // All bits clear.
    localparam logic [7:0]  CONTROL_WMASK    = 8'hbf; // Bit six absent.

    // ----------------------------------------------------------------
    // Field positions.
    // ----------------------------------------------------------------
    localparam int JUSTIFY_BIT = 7;
    localparam int ACQ_MSB     = 5;
    localparam int ACQ_LSB     = 3;
    localparam int CLK_MSB     = 2;
    localparam int CLK_LSB     = 0;

    // ----------------------------------------------------------------
    // Timing.
    // ----------------------------------------------------------------
    localparam int CLK_MHZ        = 100; // System clock rate.
    localparam int TCY_NS         = 40;  // One instruction cycle.
    localparam int TCY_CYCLES     = (TCY_NS * CLK_MHZ + 999) / 1000;
    localparam int RC_HALF_CYCLES = 8;   // Half period of the RC clock.
    localparam int CONV_PERIODS   = 11;  // Clock periods per conversion.

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sequencer states.
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_RC_DELAY,
        ST_ACQUIRE,
        ST_CONVERT
    } seq_state_t;

endpackage : adc_timing_pkg

/* rtl/adc_clock_divider.sv */
// Converter clock tick generator driven by the clock select field.
`timescale 1ns/1ps
`default_nettype none
module adc_clock_divider
(
    // Clock and reset.
    input  wire logic                 i_clk,
    input  wire logic                 i_resetn,
    // Control.
    input  wire logic                 i_run,
    input  wire logic [2:0]           i_select,
    // Tick out, one per converter clock period.
    output logic                      o_tick
);
    import adc_timing_pkg::*;

    // ----------------------------------------------------------------
    // Divide ratio decode.
    // ----------------------------------------------------------------
    // Returns the system clocks per converter clock period.
    function automatic logic [6:0] period_of(input logic [2:0] sel);
        logic [6:0] p;
        p = 7'h02;
        case (sel)
            3'h0: p = 7'h02;
            3'h1: p = 7'h08;
            3'h2: p = 7'h20;
            3'h4: p = 7'h04;
            3'h5: p = 7'h10;
            3'h6: p = 7'h40;
            default: p = 7'(2 * RC_HALF_CYCLES); // RC oscillator.
        endcase
        return p;
    endfunction : period_of

    logic [6:0] count_reg;  // Clocks elapsed in the current period.
    logic [6:0] count_next;
    logic       tick_next;

    // Count while running; restart from zero whenever stopped.
    always_comb
    begin
        count_next = 7'h00;
        tick_next  = 1'b0;
        if (i_run)
        begin
            if (count_reg == period_of(i_select) - 7'h01)
            begin
                tick_next = 1'b1;
            end
            else
            begin
                count_next = count_reg + 7'h01;
            end
        end
    end

    // Register stage.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            count_reg <= 7'h00;
            o_tick    <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            o_tick    <= tick_next;
        end
    end
endmodule : adc_clock_divider
`default_nettype wire

/* rtl/adc_timing_control.sv */
// AXI4-Lite control register and acquisition/conversion sequencer.
// How it works
// - bit seven set gives right justified result
// - bit six reads zero, writes ignored
// - acquisition code maps to 0..20 clock periods
// - clock code selects divider or RC oscillator
// - RC clock start delayed one instruction cycle
// - reset clears all control bits
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adc_timing_control
(
    // Clock and reset.
    input  wire logic                 I_CLK,
    input  wire logic                 I_RESETN,
    // AXI4-Lite write address and data.
    input  wire logic [3:0]           I_AWADDR,
    input  wire logic                 I_AWVALID,
    output logic                      O_AWREADY,
    input  wire logic [31:0]          I_WDATA,
    input  wire logic [3:0]           I_WSTRB,
    input  wire logic                 I_WVALID,
    output logic                      O_WREADY,
    // AXI4-Lite write response.
    output logic [1:0]                O_BRESP,
    output logic                      O_BVALID,
    input  wire logic                 I_BREADY,
    // AXI4-Lite read.
    input  wire logic [3:0]           I_ARADDR,
    input  wire logic                 I_ARVALID,
    output logic                      O_ARREADY,
    output logic [31:0]               O_RDATA,
    output logic [1:0]                O_RRESP,
    output logic                      O_RVALID,
    input  wire logic                 I_RREADY,
    // Converter side.
    input  wire logic                 I_START,
    output logic                      O_RESULT_JUSTIFY,
    output logic                      O_ACQUIRING,
    output logic                      O_CONVERTING,
    output logic                      O_CONV_CLK_TICK,
    output logic                      O_DONE
);
    import adc_timing_pkg::*;

    // ----------------------------------------------------------------
    // Decode helpers.
    // ----------------------------------------------------------------
    // Acquisition length in converter clock periods.
    function automatic logic [4:0] acq_periods(input logic [2:0] code);
        logic [4:0] n;
        n = 5'h00;
        case (code)
            3'h0: n = 5'h00;
            3'h1: n = 5'h02;
            3'h2: n = 5'h04;
            3'h3: n = 5'h06;
            3'h4: n = 5'h08;
            3'h5: n = 5'h0c;
            3'h6: n = 5'h10;
            default: n = 5'h14;
        endcase
        return n;
    endfunction : acq_periods

    // True when the clock code picks the RC oscillator.
    function automatic logic is_rc(input logic [2:0] code);
        return code[1:0] == 2'h3;
    endfunction : is_rc

    // ----------------------------------------------------------------
    // Register bus state.
    // ----------------------------------------------------------------
    logic [7:0]  control_reg;   // Stored control byte.
    logic [7:0]  control_next;
    logic        aw_reg,  aw_next;    // Address held until both arrive.
    logic [3:0]  awa_reg, awa_next;
    logic        w_reg,   w_next;     // Data held until both arrive.
    logic [7:0]  wd_reg,  wd_next;
    logic        ws_reg,  ws_next;    // Low byte strobe.
    logic [1:0]  bresp_next;
    logic        bvalid_next;
    logic [31:0] rdata_next;
    logic [1:0]  rresp_next;
    logic        rvalid_next;

    // Sequencer state.
    seq_state_t  state_reg, state_next;
    logic [4:0]  cnt_reg,   cnt_next;   // Periods or cycles left.
    logic        done_next;
    logic        tick;                  // Converter clock period tick.
    logic        run;

    // ----------------------------------------------------------------
    // Write and read channels.
    // ----------------------------------------------------------------
    // Address and data are taken in either order; ready is dropped
    // while a channel is held or a response is pending, so one write
    // and one read at a time are served.
    always_comb
    begin
        control_next = control_reg;
        aw_next      = aw_reg;
        awa_next     = awa_reg;
        w_next       = w_reg;
        wd_next      = wd_reg;
        ws_next      = ws_reg;
        bresp_next   = O_BRESP;
        bvalid_next  = O_BVALID;
        rdata_next   = O_RDATA;
        rresp_next   = O_RRESP;
        rvalid_next  = O_RVALID;
        if (I_AWVALID && O_AWREADY)
        begin
            aw_next  = 1'b1;
            awa_next = I_AWADDR;
        end
        if (I_WVALID && O_WREADY)
        begin
            w_next  = 1'b1;
            wd_next = I_WDATA[7:0];
            ws_next = I_WSTRB[0];
        end
        if (O_BVALID && I_BREADY)
            bvalid_next = 1'b0;
        // Both halves present: commit and respond.
        if (aw_reg && w_reg && !O_BVALID)
        begin
            aw_next     = 1'b0;
            w_next      = 1'b0;
            bvalid_next = 1'b1;
            if (awa_reg == ADDR_CONTROL_TWO)
            begin
                bresp_next = RESP_OKAY;
                // Bit six is masked so it never stores.
                if (ws_reg)
                    control_next = wd_reg & CONTROL_WMASK;
            end
            else if (awa_reg == ADDR_STATUS)
                bresp_next = RESP_OKAY; // Status is read only.
            else
                bresp_next = RESP_SLVERR;
        end
        if (O_RVALID && I_RREADY)
            rvalid_next = 1'b0;
        if (I_ARVALID && O_ARREADY)
        begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            if (I_ARADDR == ADDR_CONTROL_TWO)
                rdata_next = {24'h000000, control_reg};
            else if (I_ARADDR == ADDR_STATUS)
                rdata_next = {29'h00000000, O_DONE, O_CONVERTING,
                              O_ACQUIRING};
            else
            begin
                rdata_next = 32'h00000000;
                rresp_next = RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer.
    // ----------------------------------------------------------------
    // A start request is ignored while a sequence is under way.
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        done_next  = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (I_START)
                begin
                    cnt_next   = acq_periods(control_reg[ACQ_MSB:ACQ_LSB]);
                    state_next = ST_ACQUIRE;
                end
            end
            ST_ACQUIRE:
            begin
                // Zero code passes straight through; software is
                // expected to avoid it for accuracy.
                if (cnt_reg == 5'h00)
                begin
                    if (is_rc(control_reg[CLK_MSB:CLK_LSB]))
                    begin
                        cnt_next   = 5'(TCY_CYCLES);
                        state_next = ST_RC_DELAY;
                    end
                    else
                    begin
                        cnt_next   = 5'(CONV_PERIODS);
                        state_next = ST_CONVERT;
                    end
                end
                else if (tick)
                    cnt_next = cnt_reg - 5'h01;
            end
            ST_RC_DELAY:
            begin
                // Hold the RC clock off for one instruction cycle.
                if (cnt_reg <= 5'h01)
                begin
                    cnt_next   = 5'(CONV_PERIODS);
                    state_next = ST_CONVERT;
                end
                else
                    cnt_next = cnt_reg - 5'h01;
            end
            ST_CONVERT:
            begin
                if (tick)
                begin
                    if (cnt_reg == 5'h01)
                    begin
                        done_next  = 1'b1;
                        state_next = ST_IDLE;
                    end
                    cnt_next = cnt_reg - 5'h01;
                end
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    // The divider only runs while periods are being counted.
    assign run = (state_reg == ST_ACQUIRE) || (state_reg == ST_CONVERT);

    adc_clock_divider u_div
    (
        .i_clk    (I_CLK),
        .i_resetn (I_RESETN),
        .i_run    (run),
        .i_select (control_reg[CLK_MSB:CLK_LSB]),
        .o_tick   (tick)
    );

    // ----------------------------------------------------------------
    // Registers and outputs.
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            control_reg      <= CONTROL_RESET;
            aw_reg           <= 1'b0;
            awa_reg          <= 4'h0;
            w_reg            <= 1'b0;
            wd_reg           <= 8'h00;
            ws_reg           <= 1'b0;
            O_AWREADY        <= 1'b0;
            O_WREADY         <= 1'b0;
            O_ARREADY        <= 1'b0;
            O_BRESP          <= RESP_OKAY;
            O_BVALID         <= 1'b0;
            O_RDATA          <= 32'h00000000;
            O_RRESP          <= RESP_OKAY;
            O_RVALID         <= 1'b0;
            state_reg        <= ST_IDLE;
            cnt_reg          <= 5'h00;
            O_RESULT_JUSTIFY <= 1'b0;
            O_ACQUIRING      <= 1'b0;
            O_CONVERTING     <= 1'b0;
            O_CONV_CLK_TICK  <= 1'b0;
            O_DONE           <= 1'b0;
        end
        else
        begin
            control_reg      <= control_next;
            aw_reg           <= aw_next;
            awa_reg          <= awa_next;
            w_reg            <= w_next;
            wd_reg           <= wd_next;
            ws_reg           <= ws_next;
            O_AWREADY        <= !aw_next && !bvalid_next && !O_AWREADY;
            O_WREADY         <= !w_next && !bvalid_next && !O_WREADY;
            O_ARREADY        <= !rvalid_next && !O_ARREADY;
            O_BRESP          <= bresp_next;
            O_BVALID         <= bvalid_next;
            O_RDATA          <= rdata_next;
            O_RRESP          <= rresp_next;
            O_RVALID         <= rvalid_next;
            state_reg        <= state_next;
            cnt_reg          <= cnt_next;
            O_RESULT_JUSTIFY <= control_next[JUSTIFY_BIT];
            O_ACQUIRING      <= state_next == ST_ACQUIRE;
            O_CONVERTING     <= state_next == ST_CONVERT;
            O_CONV_CLK_TICK  <= tick && (state_reg == ST_CONVERT);
            O_DONE           <= done_next;
        end
    end
endmodule : adc_timing_control
`default_nettype wire

/* tb/adc_timing_monitor.sv */
// Checker for the converter timing control block.
`timescale 1ns/1ps
`default_nettype none
module adc_timing_monitor
(
    // Clock and reset.
    input  wire logic        I_CLK,
    input  wire logic        I_RESETN,
    // Register bus.
    input  wire logic        I_AWVALID,
    input  wire logic        O_AWREADY,
    input  wire logic        I_WVALID,
    input  wire logic        O_WREADY,
    input  wire logic        O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic        I_ARVALID,
    input  wire logic        O_ARREADY,
    input  wire logic [31:0] O_RDATA,
    input  wire logic        O_RVALID,
    // Converter side.
    input  wire logic        I_START,
    input  wire logic        O_RESULT_JUSTIFY,
    input  wire logic        O_ACQUIRING,
    input  wire logic        O_CONVERTING,
    input  wire logic        O_CONV_CLK_TICK,
    input  wire logic        O_DONE
);
    // Busy spans the RC gap, where neither phase flag is high.
    logic       busy_reg;
    logic [7:0] ticks_reg; // Ticks seen in the current conversion.

    always_ff @(posedge I_CLK)
    begin
        busy_reg  <= I_RESETN && !O_DONE &&
                     (busy_reg || O_ACQUIRING || O_CONVERTING);
        ticks_reg <= (!I_RESETN || !O_CONVERTING) ? 8'h00 :
                     ticks_reg + 8'(O_CONV_CLK_TICK);
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);

    // The RC start delay is four system cycles at this clock rate.
    sequence s_rc_gap;
        (!O_ACQUIRING && !O_CONVERTING)[*4] ##1 O_CONVERTING;
    endsequence
    sequence s_take_both;
        I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
    endsequence

    property p_justify;
        $changed(O_RESULT_JUSTIFY) |-> $rose(O_BVALID);
    endproperty
    a_justify: assert property (p_justify)
        else $error("justify output moved without a write");
    property p_rdata;
        O_RVALID |-> O_RDATA[31:8] == 24'h0 && !O_RDATA[6];
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("unimplemented read bits not zero");
    property p_start;
        I_START && !O_ACQUIRING && !O_CONVERTING && (!busy_reg || O_DONE)
            |=> O_ACQUIRING;
    endproperty
    a_start: assert property (p_start)
        else $error("start while idle did not begin acquisition");
    property p_rc_gap;
        $fell(O_ACQUIRING) && !O_CONVERTING |-> s_rc_gap;
    endproperty
    a_rc_gap: assert property (p_rc_gap)
        else $error("RC start delay length wrong");
    // The last tick shows with done, after the phase flag has fallen.
    property p_done;
        O_DONE |-> ($fell(O_CONVERTING) && O_CONV_CLK_TICK &&
                    ticks_reg == 8'h0a) ##1 !O_DONE;
    endproperty
    a_done: assert property (p_done)
        else $error("done pulse or tick count wrong");
    property p_tick;
        O_CONV_CLK_TICK |-> $past(O_CONVERTING);
    endproperty
    a_tick: assert property (p_tick)
        else $error("converter tick outside conversion");
    property p_excl;
        !(O_ACQUIRING && O_CONVERTING);
    endproperty
    a_excl: assert property (p_excl)
        else $error("acquiring and converting together");
    property p_write_ans;
        s_take_both |-> ##[1:2] O_BVALID;
    endproperty
    a_write_ans: assert property (p_write_ans)
        else $error("write response late");
    property p_read_ans;
        I_ARVALID && O_ARREADY |-> ##[1:2] O_RVALID;
    endproperty
    a_read_ans: assert property (p_read_ans)
        else $error("read data late");
    property p_b_drop;
        O_BVALID && I_BREADY |=> !O_BVALID;
    endproperty
    a_b_drop: assert property (p_b_drop)
        else $error("write response held after taken");
endmodule : adc_timing_monitor

bind adc_timing_control adc_timing_monitor u_monitor (.*);
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the converter timing control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adc_timing_pkg::*;
    // Stimulus, all given a value at time zero.
    logic I_CLK = 1'b0, I_RESETN = 1'b0, I_START = 1'b0;
    logic [3:0] I_AWADDR = 4'h0, I_ARADDR = 4'h0, I_WSTRB = 4'h0;
    logic [31:0] I_WDATA = 32'h0;
    logic I_AWVALID = 1'b0, I_WVALID = 1'b0, I_BREADY = 1'b0;
    logic I_ARVALID = 1'b0, I_RREADY = 1'b0;
    // Observed outputs.
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    logic [1:0] O_BRESP, O_RRESP;
    logic [31:0] O_RDATA;
    logic O_RESULT_JUSTIFY, O_ACQUIRING, O_CONVERTING;
    logic O_CONV_CLK_TICK, O_DONE;
    int failures = 0, checked = 0, cycles = 0;
    // Periods per acquisition code; divider per clock code (RC is 16).
    int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int div_tab[8] = '{2, 8, 32, 16, 4, 16, 64, 16};

    adc_timing_control dut (.*);

    always #5 I_CLK = ~I_CLK;

    // Cuts a hang short; the whole run needs a few thousand cycles.
    always @(posedge I_CLK)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            failures++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("counts: %0d compared, %0d wrong", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    task automatic do_reset();
        I_RESETN <= 1'b0;
        repeat (10) @(posedge I_CLK);
        I_RESETN <= 1'b1;
        repeat (2) @(posedge I_CLK);
    endtask : do_reset

    // Both channels offered together; each released when taken.
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        I_AWADDR <= a;
        I_AWVALID <= 1'b1;
        I_WDATA <= d;
        I_WSTRB <= s;
        I_WVALID <= 1'b1;
        I_BREADY <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge I_CLK);
            if (I_AWVALID && O_AWREADY)
            begin
                aw_ok = 1'b1;
                I_AWVALID <= 1'b0;
            end
            if (I_WVALID && O_WREADY)
            begin
                w_ok = 1'b1;
                I_WVALID <= 1'b0;
            end
        end
        do
            @(posedge I_CLK);
        while (O_BVALID !== 1'b1);
        r = O_BRESP;
        I_BREADY <= 1'b0;
        @(posedge I_CLK);
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        I_ARADDR <= a;
        I_ARVALID <= 1'b1;
        I_RREADY <= 1'b1;
        do
            @(posedge I_CLK);
        while (!(I_ARVALID && O_ARREADY));
        I_ARVALID <= 1'b0;
        do
            @(posedge I_CLK);
        while (O_RVALID !== 1'b1);
        d = O_RDATA;
        r = O_RRESP;
        I_RREADY <= 1'b0;
        @(posedge I_CLK);
    endtask : axi_read

    // Start held high through acquisition so a busy start is ignored.
    task automatic run_seq(input logic [7:0] ctrl, output int acq,
                           output int gap, output int conv,
                           output int ticks, output int starts);
        logic [1:0] r;
        logic was_acq;
        axi_write(ADDR_CONTROL_TWO, {24'h0, ctrl}, 4'hf, r);
        acq = 0;
        gap = 0;
        conv = 0;
        ticks = 0;
        starts = 0;
        was_acq = 1'b0;
        I_START <= 1'b1;
        do
        begin
            @(posedge I_CLK);
            if (conv > 0)
                I_START <= 1'b0;
            #1;
            if (O_ACQUIRING && !was_acq)
                starts++;
            was_acq = O_ACQUIRING;
            acq += int'(O_ACQUIRING);
            conv += int'(O_CONVERTING);
            ticks += int'(O_CONV_CLK_TICK);
            if (!O_ACQUIRING && !O_CONVERTING && acq > 0 && conv == 0)
                gap++;
        end
        while (O_DONE !== 1'b1);
        @(posedge I_CLK);
    endtask : run_seq

    task automatic t_registers();
        logic [31:0] d;
        logic [1:0] r;
        axi_read(ADDR_CONTROL_TWO, d, r);
        check(d, 32'h0);
        axi_write(ADDR_CONTROL_TWO, 32'hff, 4'hf, r);
        check(32'(O_RESULT_JUSTIFY), 32'h1);
        axi_write(ADDR_CONTROL_TWO, 32'h00, 4'h0, r);
        axi_write(ADDR_STATUS, 32'h00, 4'hf, r);
        check(32'(r), 32'(RESP_OKAY));
        axi_read(ADDR_CONTROL_TWO, d, r);
        check(d, 32'hbf);
        axi_write(4'h8, 32'h00, 4'hf, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_read(4'h8, d, r);
        check(d, 32'h0);
        check(32'(r), 32'(RESP_SLVERR));
        axi_write(ADDR_CONTROL_TWO, 32'h7f, 4'hf, r);
        check(32'(O_RESULT_JUSTIFY), 32'h0);
        axi_read(ADDR_CONTROL_TWO, d, r);
        check(d, 32'h3f);
        do_reset();
        axi_read(ADDR_CONTROL_TWO, d, r);
        check(d, 32'h0);
        $display("test registers done");
    endtask : t_registers

    task automatic t_acq_codes();
        int acq, gap, conv, ticks, starts, p;
        for (int c = 0; c < 8; c++)
        begin
            run_seq({2'b00, 3'(c), 3'b000}, acq, gap, conv, ticks, starts);
            p = 2 * acq_tab[c];
            check(32'(acq > p && acq <= p + 2), 32'h1);
            check(starts, 1);
            check(ticks, CONV_PERIODS);
        end
        $display("test acquisition codes done");
    endtask : t_acq_codes

    task automatic t_clock_codes();
        int acq, gap, conv, ticks, starts, d;
        for (int c = 0; c < 8; c++)
        begin
            // Acquisition code one keeps clear of the zero code.
            run_seq({5'b00001, 3'(c)}, acq, gap, conv, ticks, starts);
            d = div_tab[c];
            check((conv + d / 2) / d, CONV_PERIODS);
            check(gap, (c % 4 == 3) ? TCY_CYCLES : 0);
            check(ticks, CONV_PERIODS);
        end
        $display("test clock codes done");
    endtask : t_clock_codes

    initial
    begin
        do_reset();
        check(32'(O_RESULT_JUSTIFY), 32'h0);
        t_registers();
        t_acq_codes();
        t_clock_codes();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
